// >>> ram_power_cfg.svh
// Constants for the cluster RAM power state decoder.
`ifndef RAM_POWER_CFG_SVH
`define RAM_POWER_CFG_SVH
`define NUM_SLICES 8
`define WAYS_PER_PORTION 8
`define NUM_PARTITIONS 8
`define ADDR_TARGET 4'h0
`define ADDR_CURRENT 4'h1
`define ADDR_CONFIG 4'h2
`define ADDR_SLICE_RAMS 4'h3
`define ADDR_DOMAINS 4'h4
`define ADDR_PORTION_WAYS 4'h5
`define RST_POWER_MODE 4'h0
`define RST_SLICE_MODE 1'h1
`define RST_RAM_MODE 2'h2
`endif

// >>> ram_power_pkg.sv
// Types for the cluster RAM power state decoder.
package ram_power_pkg;
    typedef enum logic [3:0] {
        PM_ON = 4'h0,
        PM_WARM_RST = 4'h1,
        PM_DEBUG_RECOVERY = 4'h2,
        PM_EMU_MEMORY_RETENTION_MODE = 4'h3,
        PM_EMU_OFF = 4'h4,
        PM_FUNCTIONAL_RETENTION_MODE = 4'h5,
        PM_FULL_RETENTION_MODE = 4'h6,
        PM_MEMORY_RETENTION_MODE = 4'h7,
        PM_OFF = 4'h8
    } power_mode_e;
    typedef enum logic [2:0] {
        PS_ON = 3'h0,
        PS_FUNCTIONAL_RETENTION_MODE = 3'h1,
        PS_FULL_RETENTION_MODE = 3'h2,
        PS_MEMORY_RETENTION_MODE = 3'h3,
        PS_OFF = 3'h4
    } power_state_e;
    typedef enum logic [1:0] {
        RS_OFF = 2'h0,
        RS_RET = 2'h1,
        RS_ON = 2'h2
    } ram_state_e;
    typedef enum logic [1:0] {
        RM_SF_ONLY = 2'h0,
        RM_HALF = 2'h1,
        RM_FULL = 2'h2
    } ram_mode_e;
    typedef enum logic {
        SM_ONE = 1'h0,
        SM_ALL = 1'h1
    } slice_mode_e;
    typedef struct packed {
        power_mode_e power;
        slice_mode_e slices;
        ram_mode_e rams;
    } combined_mode_s;
    typedef struct packed {
        ram_state_e portion1;
        ram_state_e portion0;
        ram_state_e snoop_filter;
        logic slice_logic_on;
    } slice_power_s;
endpackage : ram_power_pkg

// >>> cluster_ram_power_state_decoder.sv
// Cluster power policy unit decoding combined modes into RAM and domain power requests.
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/1ns
`include "ram_power_cfg.svh"

module cluster_ram_power_state_decoder #(
    parameter bit HAS_L3 = 1'b1,
    parameter int SLICES_BUILT = `NUM_SLICES
) (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic i_req_valid,
    output logic o_req_stall,
    output ram_power_pkg::power_state_e o_power_state_request,
    output ram_power_pkg::slice_power_s [`NUM_SLICES-1:0] o_slice_power,
    output logic o_cluster_logic_on,
    output logic [`NUM_PARTITIONS-1:0] o_partition_way_mask,
    output logic o_cache_coherent
);
    ram_power_pkg::combined_mode_s target_q;
    ram_power_pkg::combined_mode_s current_q;
    ram_power_pkg::combined_mode_s next_step;
    ram_power_pkg::combined_mode_s wr_mode;
    ram_power_pkg::slice_power_s [`NUM_SLICES-1:0] slice_d;
    ram_power_pkg::power_state_e state_d;
    logic cluster_d;
    logic in_on_group;
    logic accept;
    logic reset_done_q;

    // An on-group mode permits every operating mode only for plain on and emulated retention.
    function automatic logic is_on_group(input ram_power_pkg::power_mode_e m);
        is_on_group = (m == ram_power_pkg::PM_ON) || (m == ram_power_pkg::PM_WARM_RST) ||
            (m == ram_power_pkg::PM_DEBUG_RECOVERY) || (m == ram_power_pkg::PM_EMU_MEMORY_RETENTION_MODE) ||
            (m == ram_power_pkg::PM_EMU_OFF);
    endfunction : is_on_group

    // Illegal targets are corrected on write so that the stepping logic only sees legal ones.
    always_comb begin
        wr_mode = ram_power_pkg::combined_mode_s'(i_wdata[6:0]);
        if (wr_mode.power > ram_power_pkg::PM_OFF) begin
            wr_mode.power = ram_power_pkg::PM_OFF;
        end
        if (wr_mode.rams > ram_power_pkg::RM_FULL) begin
            wr_mode.rams = ram_power_pkg::RM_FULL;
        end
        if (SLICES_BUILT == 1) begin
            wr_mode.slices = ram_power_pkg::SM_ALL;
        end
        if (is_on_group(wr_mode.power) && wr_mode.power != ram_power_pkg::PM_ON &&
            wr_mode.power != ram_power_pkg::PM_EMU_MEMORY_RETENTION_MODE) begin
            wr_mode.rams = ram_power_pkg::RM_FULL;
        end
        if (!HAS_L3) begin
            wr_mode.rams = ram_power_pkg::RM_SF_ONLY;
            wr_mode.slices = ram_power_pkg::SM_ALL;
        end
    end

    // One step toward the target: leaving off loads the target, power on unless on-group; otherwise operating modes change only in on, one field at a time.
    always_comb begin
        next_step = current_q;
        if (current_q.power == ram_power_pkg::PM_OFF && target_q.power != ram_power_pkg::PM_OFF) begin
            next_step = target_q;
            if (!is_on_group(target_q.power)) begin
                next_step.power = ram_power_pkg::PM_ON;
            end
        end else if (current_q.slices != target_q.slices || current_q.rams != target_q.rams) begin
            if (current_q.power != ram_power_pkg::PM_ON) begin
                next_step.power = ram_power_pkg::PM_ON;
            end else if (current_q.slices != target_q.slices) begin
                next_step.slices = target_q.slices;
            end else if (current_q.rams < target_q.rams) begin
                next_step.rams = ram_power_pkg::ram_mode_e'(current_q.rams + 2'h1);
            end else begin
                next_step.rams = ram_power_pkg::ram_mode_e'(current_q.rams - 2'h1);
            end
        end else if (current_q.power != target_q.power) begin
            if (!is_on_group(current_q.power) && !is_on_group(target_q.power) &&
                !((current_q.power == ram_power_pkg::PM_FUNCTIONAL_RETENTION_MODE && target_q.power == ram_power_pkg::PM_FULL_RETENTION_MODE) ||
                  (current_q.power == ram_power_pkg::PM_FULL_RETENTION_MODE && target_q.power == ram_power_pkg::PM_FUNCTIONAL_RETENTION_MODE))) begin
                next_step.power = ram_power_pkg::PM_ON;
            end else begin
                next_step.power = target_q.power;
            end
        end
    end
    assign accept = (next_step != current_q);

    // Register writes set the target; the unit, not software, chooses the reset mode.
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            target_q <= '{ram_power_pkg::power_mode_e'(`RST_POWER_MODE), ram_power_pkg::slice_mode_e'(`RST_SLICE_MODE),
                ram_power_pkg::ram_mode_e'(`RST_RAM_MODE)};
        end else if (i_wr && i_addr == `ADDR_TARGET) begin
            target_q <= wr_mode;
        end
    end

    // The current mode starts off and takes one step per cycle.
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            current_q <= '{ram_power_pkg::PM_OFF, ram_power_pkg::SM_ALL, ram_power_pkg::RM_FULL};
            reset_done_q <= 1'b0;
        end else begin
            reset_done_q <= 1'b1;
            if (accept) begin
                current_q <= next_step;
            end
        end
    end

    // Decode of the next mode into the power state request and the cluster logic request.
    always_comb begin
        in_on_group = is_on_group(next_step.power);
        state_d = ram_power_pkg::PS_OFF;
        cluster_d = 1'b0;
        unique case (next_step.power)
            ram_power_pkg::PM_FUNCTIONAL_RETENTION_MODE: begin
                state_d = ram_power_pkg::PS_FUNCTIONAL_RETENTION_MODE;
                cluster_d = 1'b1;
            end
            ram_power_pkg::PM_FULL_RETENTION_MODE: begin
                state_d = ram_power_pkg::PS_FULL_RETENTION_MODE;
                cluster_d = 1'b1;
            end
            ram_power_pkg::PM_MEMORY_RETENTION_MODE: begin
                state_d = ram_power_pkg::PS_MEMORY_RETENTION_MODE;
            end
            ram_power_pkg::PM_OFF: begin
                state_d = ram_power_pkg::PS_OFF;
            end
            default: begin
                state_d = ram_power_pkg::PS_ON;
                cluster_d = 1'b1;
            end
        endcase
    end

    // The same mapping serves every slice; slices past slice 0 follow only in all-slices mode.
    for (genvar s = 0; s < `NUM_SLICES; s++) begin : g_slice
        logic active;
        ram_power_pkg::ram_state_e powered;
        assign active = (s == 0) || (next_step.slices == ram_power_pkg::SM_ALL && s < SLICES_BUILT);
        assign powered = in_on_group ? ram_power_pkg::RS_ON :
            (next_step.power == ram_power_pkg::PM_OFF) ? ram_power_pkg::RS_OFF : ram_power_pkg::RS_RET;
        always_comb begin
            slice_d[s] = '{ram_power_pkg::RS_OFF, ram_power_pkg::RS_OFF, ram_power_pkg::RS_OFF, 1'b0};
            if (active) begin
                slice_d[s].portion1 = (next_step.rams == ram_power_pkg::RM_FULL) ? powered :
                    ram_power_pkg::RS_OFF;
                slice_d[s].portion0 = (next_step.rams != ram_power_pkg::RM_SF_ONLY) ? powered :
                    ram_power_pkg::RS_OFF;
                slice_d[s].snoop_filter = (next_step.power == ram_power_pkg::PM_MEMORY_RETENTION_MODE) ? ram_power_pkg::RS_OFF :
                    powered;
                slice_d[s].slice_logic_on = in_on_group ||
                    next_step.power == ram_power_pkg::PM_FUNCTIONAL_RETENTION_MODE;
            end
        end
    end

    // Requests are registered and only move when a step is accepted, so they never glitch.
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            o_power_state_request <= ram_power_pkg::PS_OFF;
            o_slice_power <= '0;
            o_cluster_logic_on <= 1'b0;
        end else if (accept) begin
            o_power_state_request <= state_d;
            o_slice_power <= slice_d;
            o_cluster_logic_on <= cluster_d;
        end
    end

    // Each bit is one way per partition; all bits follow whether portion 1 of slice 0 is on, and portion 0 is not used.
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            o_partition_way_mask <= '0;
            o_cache_coherent <= 1'b0;
        end else begin
            o_partition_way_mask <= (o_slice_power[0].portion1 == ram_power_pkg::RS_ON) ? '1 : '0;
            o_cache_coherent <= (o_power_state_request == ram_power_pkg::PS_ON) && reset_done_q;
        end
    end

    // Functional and full retention hold off a pending core request; every other power state lets it through.
    assign o_req_stall = i_req_valid && (o_power_state_request == ram_power_pkg::PS_FUNCTIONAL_RETENTION_MODE ||
        o_power_state_request == ram_power_pkg::PS_FULL_RETENTION_MODE);

    // Read data stand one cycle after the strobe; unmapped addresses read zero.
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_rd) begin
            unique case (i_addr)
                `ADDR_TARGET: o_rdata <= {25'h0, target_q};
                `ADDR_CURRENT: o_rdata <= {25'h0, current_q};
                `ADDR_CONFIG: o_rdata <= {23'h0, 1'(HAS_L3), 4'(SLICES_BUILT), 1'b0, o_power_state_request};
                `ADDR_SLICE_RAMS: o_rdata <= {4'h0, o_slice_power[3], o_slice_power[2], o_slice_power[1],
                    o_slice_power[0]};
                `ADDR_DOMAINS: o_rdata <= {4'h0, o_slice_power[7], o_slice_power[6], o_slice_power[5],
                    o_slice_power[4]};
                `ADDR_PORTION_WAYS: o_rdata <= {23'h0, o_cluster_logic_on, o_partition_way_mask};
                default: o_rdata <= 32'h0000_0000;
            endcase
        end
    end

    stall_ret_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (i_req_valid && o_power_state_request == ram_power_pkg::PS_FULL_RETENTION_MODE) |-> o_req_stall)
        else $error("Request not stalled in retention.");
    stable_out_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        !$past(accept) |-> $stable(o_slice_power)) else $error("Outputs moved without step.");
    off_all_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        o_power_state_request == ram_power_pkg::PS_OFF |-> !o_cluster_logic_on && o_slice_power == '0)
        else $error("Off mode left power on.");
    memory_retention_mode_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        o_power_state_request == ram_power_pkg::PS_MEMORY_RETENTION_MODE |->
        o_slice_power[0].snoop_filter == ram_power_pkg::RS_OFF && !o_cluster_logic_on)
        else $error("Memory retention left logic on.");
    full_retention_mode_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        o_power_state_request == ram_power_pkg::PS_FULL_RETENTION_MODE |->
        !o_slice_power[0].slice_logic_on && o_cluster_logic_on) else $error("Full retention domains wrong.");
    functional_retention_mode_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        o_power_state_request == ram_power_pkg::PS_FUNCTIONAL_RETENTION_MODE |->
        o_slice_power[0].snoop_filter == ram_power_pkg::RS_RET && o_slice_power[0].slice_logic_on)
        else $error("Functional retention states wrong.");
    one_slice_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        current_q.slices == ram_power_pkg::SM_ONE |-> !o_slice_power[1].slice_logic_on)
        else $error("Slice 1 on in one-slice mode.");
    step_ram_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        accept && current_q.power != ram_power_pkg::PM_OFF && current_q.rams != next_step.rams |->
        current_q.power == ram_power_pkg::PM_ON)
        else $error("Operating mode changed outside on.");
    cv_full_on_c: cover property (@(posedge i_clk_sys) o_cache_coherent);
    cv_ret_stall_c: cover property (@(posedge i_clk_sys) o_req_stall);
    cv_one_slice_c: cover property (@(posedge i_clk_sys) current_q.slices == ram_power_pkg::SM_ONE);
endmodule : cluster_ram_power_state_decoder

// >>> core_request_source.sv
// Core request source that keeps a request pending while the cluster stalls it.
`timescale 1ns/1ns
module core_request_source (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_want,
    input wire logic i_stall,
    output logic o_valid,
    output logic [7:0] o_served
);
    // A request only counts as served in a cycle without stall, so a stalled one simply waits.
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            o_served <= 8'h00;
        end else if (o_valid && !i_stall) begin
            o_served <= o_served + 8'h01;
        end
    end
    // The request is a level held for as long as the bench wants service.
    assign o_valid = i_want;
endmodule : core_request_source

// >>> cluster_ram_power_state_decoder_tb.sv
// Self-checking bench for the cluster RAM power state decoder.
`timescale 1ns/1ns
`include "ram_power_cfg.svh"
module cluster_ram_power_state_decoder_tb;
    import ram_power_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_rstn = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic want = 1'b0;
    logic req_valid;
    logic [7:0] served;
    logic [31:0] rdata;
    logic stall;
    power_state_e power_state_request;
    slice_power_s [`NUM_SLICES-1:0] spow;
    logic clus_on;
    logic [`NUM_PARTITIONS-1:0] way_mask;
    logic coherent;
    int n_errors = 0;
    int checks = 0;
    // Free-running system clock.
    always #2 i_clk_sys = ~i_clk_sys;
    cluster_ram_power_state_decoder i_cluster_ram_power_state_decoder (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .i_req_valid(req_valid),
        .o_req_stall(stall), .o_power_state_request(power_state_request), .o_slice_power(spow),
        .o_cluster_logic_on(clus_on), .o_partition_way_mask(way_mask), .o_cache_coherent(coherent));
    core_request_source i_core_request_source (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_want(want),
        .i_stall(stall), .o_valid(req_valid), .o_served(served));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic results();
        $display("Mismatches %0d in %0d checks", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask : wr
    // Read data is sampled just after the edge that registers it; it then stands until the next read.
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge i_clk_sys);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 d = rdata;
    endtask : rd
    function automatic slice_power_s exp_slice(input logic [3:0] pm, input logic [1:0] rm, input bit act);
        ram_state_e lvl;
        slice_power_s s;
        lvl = (pm <= PM_EMU_OFF) ? RS_ON : RS_RET;
        s.portion1 = (rm == RM_FULL) ? lvl : RS_OFF;
        s.portion0 = (rm != RM_SF_ONLY) ? lvl : RS_OFF;
        s.snoop_filter = (pm == PM_MEMORY_RETENTION_MODE) ? RS_OFF : lvl;
        s.slice_logic_on = (pm <= PM_FUNCTIONAL_RETENTION_MODE);
        if (!act || pm >= PM_OFF) s = '0;
        return s;
    endfunction : exp_slice
    function automatic logic [2:0] exp_state(input logic [3:0] pm);
        if (pm <= PM_EMU_OFF) return PS_ON;
        if (pm >= PM_OFF) return PS_OFF;
        return pm - 4'h4;
    endfunction : exp_state
    // Program a target, wait until the unit reports it, then judge every output and the stall.
    task automatic go(input logic [3:0] wpm, input logic sm, input logic [1:0] rm, input logic [3:0] pm,
        input logic [1:0] erm);
        logic [31:0] d;
        logic [7:0] c;
        int i;
        slice_power_s s0;
        wr(`ADDR_TARGET, {25'h0, wpm, sm, rm});
        for (i = 0; i < 40; i++) begin
            rd(`ADDR_CURRENT, d);
            if (d[6:2] === {pm, sm} && (pm == PM_OFF || d[1:0] === erm)) break;
        end
        if (i == 40) begin
            check("mode reached", d, {25'h0, pm, sm, erm});
            results();
        end
        repeat (2) @(posedge i_clk_sys);
        #1;
        s0 = exp_slice(pm, erm, 1'b1);
        check("power state", {29'h0, power_state_request}, {29'h0, exp_state(pm)});
        for (int s = 0; s < `NUM_SLICES; s++) begin
            check("slice power", {25'h0, spow[s]}, {25'h0, exp_slice(pm, erm, s == 0 || sm)});
        end
        check("cluster logic", {31'h0, clus_on}, {31'h0, pm <= PM_FULL_RETENTION_MODE});
        check("way mask", {24'h0, way_mask}, {24'h0, {8{s0.portion1 == RS_ON}}});
        check("coherent", {31'h0, coherent}, {31'h0, exp_state(pm) == PS_ON});
        rd(`ADDR_CONFIG, d);
        check("config state", {29'h0, d[2:0]}, {29'h0, exp_state(pm)});
        rd(`ADDR_SLICE_RAMS, d);
        check("slice0 reg", {25'h0, d[6:0]}, {25'h0, s0});
        @(posedge i_clk_sys);
        want <= 1'b1;
        #1 c = served;
        check("stall", {31'h0, stall}, {31'h0, pm == PM_FUNCTIONAL_RETENTION_MODE || pm == PM_FULL_RETENTION_MODE});
        repeat (3) @(posedge i_clk_sys);
        want <= 1'b0;
        #1;
        check("served", {24'h0, served - c}, (pm == PM_FUNCTIONAL_RETENTION_MODE || pm == PM_FULL_RETENTION_MODE) ? 32'h0 : 32'h3);
    endtask : go
    task automatic t_reset();
        logic [31:0] d;
        repeat (3) @(posedge i_clk_sys);
        i_rstn <= 1'b1;
        #1;
        check("reset slices", {31'h0, spow != '0}, 32'h0);
        check("reset cluster", {31'h0, clus_on}, 32'h0);
        rd(`ADDR_TARGET, d);
        check("reset target", {25'h0, d[6:0]}, {25'h0, PM_ON, SM_ALL, RM_FULL});
        rd(4'hF, d);
        check("unmapped", d, 32'h0);
        go(PM_ON, SM_ALL, RM_FULL, PM_ON, RM_FULL);
    endtask : t_reset
    task automatic t_retention();
        go(PM_FUNCTIONAL_RETENTION_MODE, SM_ALL, RM_FULL, PM_FUNCTIONAL_RETENTION_MODE, RM_FULL);
        go(PM_FULL_RETENTION_MODE, SM_ALL, RM_FULL, PM_FULL_RETENTION_MODE, RM_FULL);
        go(PM_MEMORY_RETENTION_MODE, SM_ALL, RM_FULL, PM_MEMORY_RETENTION_MODE, RM_FULL);
        go(PM_FUNCTIONAL_RETENTION_MODE, SM_ALL, RM_HALF, PM_FUNCTIONAL_RETENTION_MODE, RM_HALF);
        go(PM_FULL_RETENTION_MODE, SM_ALL, RM_SF_ONLY, PM_FULL_RETENTION_MODE, RM_SF_ONLY);
        go(PM_MEMORY_RETENTION_MODE, SM_ALL, RM_HALF, PM_MEMORY_RETENTION_MODE, RM_HALF);
    endtask : t_retention
    // Among the on-group modes, half RAM survives only under plain on and emulated memory retention.
    task automatic t_on_group();
        for (int p = PM_ON; p <= PM_EMU_OFF; p++) begin
            go(p[3:0], SM_ALL, RM_HALF, p[3:0], (p == PM_ON || p == PM_EMU_MEMORY_RETENTION_MODE) ? RM_HALF : RM_FULL);
        end
        go(PM_ON, SM_ALL, RM_SF_ONLY, PM_ON, RM_SF_ONLY);
        go(PM_EMU_MEMORY_RETENTION_MODE, SM_ALL, RM_SF_ONLY, PM_EMU_MEMORY_RETENTION_MODE, RM_SF_ONLY);
    endtask : t_on_group
    task automatic t_one_slice();
        go(PM_ON, SM_ONE, RM_FULL, PM_ON, RM_FULL);
        go(PM_FUNCTIONAL_RETENTION_MODE, SM_ONE, RM_HALF, PM_FUNCTIONAL_RETENTION_MODE, RM_HALF);
        go(PM_MEMORY_RETENTION_MODE, SM_ONE, RM_FULL, PM_MEMORY_RETENTION_MODE, RM_FULL);
    endtask : t_one_slice
    // Off, then out-of-range codes that are clamped, then back to full service.
    task automatic t_off_clamp();
        go(PM_OFF, SM_ALL, RM_FULL, PM_OFF, RM_FULL);
        go(PM_ON, SM_ALL, 2'h3, PM_ON, RM_FULL);
        go(4'hF, SM_ALL, RM_FULL, PM_OFF, RM_FULL);
        go(PM_ON, SM_ALL, RM_FULL, PM_ON, RM_FULL);
    endtask : t_off_clamp
    // Main sequence.
    initial begin
        t_reset();
        t_retention();
        t_on_group();
        t_one_slice();
        t_off_clamp();
        results();
    end
endmodule : cluster_ram_power_state_decoder_tb
